//--- design/dpm_pkg.sv
// constants, codes and state types of the dram power-state controller
// assumes a 125 MHz system clock; all times rounded to whole clock cycles here
package dpm_pkg;

	// clock
	localparam int CLK_PERIOD_NS = 8;

	// timing, in ns as specified, then in cycles
	localparam int ENTRY_QUIET_NS     = 40;
	localparam int LIGHT_REENTRY_NS   = 200;
	localparam int LIGHT_REEXIT_NS    = 200;
	localparam int DEEP_REENTRY_NS    = 800;
	localparam int DEEP_REEXIT_NS     = 800;
	localparam int CHAN_STABLE_NS     = 400;
	localparam int WAKE_QUIET_NS      = 40;
	localparam int LIGHT_LIMIT_NS     = 10000;
	localparam int LIGHT_MARGIN_CYC   = 64;

	localparam logic [7:0]  ENTRY_QUIET_CYC   = 8'((ENTRY_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0]  LIGHT_REENTRY_CYC = 8'((LIGHT_REENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0]  LIGHT_REEXIT_CYC  = 8'((LIGHT_REEXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0]  DEEP_REENTRY_CYC  = 8'((DEEP_REENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0]  DEEP_REEXIT_CYC   = 8'((DEEP_REEXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [6:0]  CHAN_STABLE_CYC   = 7'((CHAN_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0]  WAKE_QUIET_CYC    = 8'((WAKE_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [10:0] LIGHT_WAKE_AT_CYC = 11'(LIGHT_LIMIT_NS / CLK_PERIOD_NS - LIGHT_MARGIN_CYC);

	// serial clock made here: half period in system cycles, wake steps
	localparam logic [1:0] SCK_HALF_LAST = 2'h3;
	localparam logic [2:0] WAKE_LAST_STEP = 3'h5;

	// software register indices
	localparam logic [3:0] REG_CMD    = 4'h0;
	localparam logic [3:0] REG_CFG    = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;

	// command register fields
	localparam int CMD_CODE_LSB = 0;
	localparam int CMD_BCAST    = 4;

	// configuration register fields and reset value
	localparam int CFG_WAKE_SEL   = 0;
	localparam int CFG_SLOT_SEL   = 1;
	localparam int CFG_LIGHT_SR   = 2;
	localparam int CFG_FRAME_LSB  = 3;
	localparam int CFG_AUTO_RENAP = 7;
	localparam int CFG_DEV_LSB    = 8;
	localparam logic [15:0] CFG_RESET = 16'h00BA;

	// status register fields
	localparam int ST_PWR_LSB  = 0;
	localparam int ST_BUSY     = 6;
	localparam int ST_REFUSED  = 7;
	localparam int ST_COND     = 8;
	localparam int ST_CHAN_OK  = 9;
	localparam int ST_RENAP    = 10;

	// software commands
	localparam logic [3:0] CMD_ACTIVATE  = 4'h1;
	localparam logic [3:0] CMD_ATTENTION = 4'h2;
	localparam logic [3:0] CMD_ROW_RELAX = 4'h3;
	localparam logic [3:0] CMD_COL_RELAX = 4'h4;
	localparam logic [3:0] CMD_LOAD      = 4'h5;
	localparam logic [3:0] CMD_STORE     = 4'h6;
	localparam logic [3:0] CMD_LIGHT     = 4'h7;
	localparam logic [3:0] CMD_DEEP      = 4'h8;
	localparam logic [3:0] CMD_COND      = 4'h9;
	localparam logic [3:0] CMD_WAKE      = 4'hA;

	// row packet operations
	localparam logic [2:0] ROW_OP_ACTIVATE = 3'h1;
	localparam logic [2:0] ROW_OP_ATTENTION_STATE     = 3'h2;
	localparam logic [2:0] ROW_OP_RELAX    = 3'h3;
	localparam logic [2:0] ROW_OP_LIGHT    = 3'h4;
	localparam logic [2:0] ROW_OP_DEEP     = 3'h5;
	localparam logic [2:0] ROW_OP_COND     = 3'h6;

	// column packet operations
	localparam logic [2:0] COL_OP_RETIRE = 3'h1;
	localparam logic [2:0] COL_OP_PRECH  = 3'h2;
	localparam logic [2:0] COL_OP_RELAX  = 3'h3;
	localparam logic [2:0] COL_OP_LOAD   = 3'h4;
	localparam logic [2:0] COL_OP_STORE  = 3'h5;

	// mirrored power state of the device
	typedef enum logic [5:0] {
		deep_sleep_state      = 6'h01,
		standby_state         = 6'h02,
		attention_state       = 6'h04,
		attention_read_state  = 6'h08,
		attention_write_state = 6'h10,
		light_sleep_state     = 6'h20
	} dpm_pwr_t;

	// controller sequencing state
	typedef enum logic [5:0] {
		seq_idle   = 6'h01,
		seq_retire = 6'h02,
		seq_prech  = 6'h04,
		seq_req    = 6'h08,
		seq_quiet  = 6'h10,
		seq_wake   = 6'h20
	} dpm_seq_t;

endpackage

//--- design/dpm_wake_if.sv
// hand-off between the power-state controller and its serial wake sequencer
// both ends run on the same system clock
`timescale 1ns/1ns
`default_nettype none
interface dpm_wake_if;
	logic       start;
	logic       deep;
	logic [5:0] dev;
	logic       wake_select_bit;
	logic       slot;
	logic       done;

	modport ctl (output start, output deep, output dev, output wake_select_bit, output slot, input done);
	modport seq (input start, input deep, input dev, input wake_select_bit, input slot, output done);
endinterface
`default_nettype wire

//--- design/dpm_wake_seq.sv
// serial wake sequencer: makes the serial clock and the command, serial
// input and device-number pattern; started by the controller, one pulse done
`timescale 1ns/1ns
`default_nettype none
module dpm_wake_seq (
	// clock and reset
	input  wire logic     clock_i,
	input  wire logic     rst_b_i,
	// controller side
	dpm_wake_if.seq       wk,
	// serial pins
	output logic          sck_o,
	output logic          cmd_o,
	output logic          serial_input_zero_o,
	output logic [5:0]    dqa_o,
	output logic          dqa_oe_o
);
	logic       active_q, active_d;
	logic [2:0] step_q, step_d;
	logic [1:0] half_q, half_d;
	logic       deep_q, deep_d;
	logic [5:0] dev_q, dev_d;
	logic       psx_q, psx_d;
	logic       slot_q, slot_d;
	logic       sck_d, cmd_d, sio_d, oe_d, done_d;
	logic [5:0] dqa_d;
	logic       done_q;

	always_comb begin
		logic [2:0] nstep;
		logic       drive;
		logic       apply;
		nstep    = step_q;
		drive    = 1'b0;
		apply    = 1'b0;
		active_d = active_q;
		step_d   = step_q;
		half_d   = half_q;
		deep_d   = deep_q;
		dev_d    = dev_q;
		psx_d    = psx_q;
		slot_d   = slot_q;
		sck_d    = sck_o;
		cmd_d    = cmd_o;
		sio_d    = serial_input_zero_o;
		oe_d     = dqa_oe_o;
		dqa_d    = dqa_o;
		done_d   = 1'b0;
		if (!active_q) begin
			if (wk.start) begin
				active_d = 1'b1;
				deep_d   = wk.deep;
				dev_d    = wk.dev;
				psx_d    = wk.wake_select_bit;
				slot_d   = wk.slot;
				half_d   = 2'h0;
				nstep    = 3'h0;
				apply    = 1'b1;
			end
		end else if (half_q != dpm_pkg::SCK_HALF_LAST) begin
			half_d = half_q + 2'h1;
		end else if (step_q == dpm_pkg::WAKE_LAST_STEP) begin
			active_d = 1'b0;
			done_d   = 1'b1;
		end else begin
			half_d = 2'h0;
			nstep  = step_q + 3'h1;
			apply  = 1'b1;
		end
		if (apply) begin
			step_d = nstep;
			// edges: rise at step 0, falls at 1, 3 and 5, rises at 2 and 4
			sck_d  = ~nstep[0];
			// 0 seen at the fall, 1 at the following rise
			cmd_d  = (nstep == 3'h1);
			sio_d  = (nstep <= 3'h1) ? (active_d ? deep_d : 1'b0) : 1'b0;
			// number stands across the rise 0.5 or 1.5 cycles after the fall
			drive  = !psx_d && (slot_d ? (nstep == 3'h3 || nstep == 3'h4) : (nstep == 3'h1 || nstep == 3'h2));
			oe_d   = drive;
			dqa_d  = drive ? dev_d : 6'h00;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			active_q <= 1'b0;
			step_q   <= 3'h0;
			half_q   <= 2'h0;
			deep_q   <= 1'b0;
			dev_q    <= 6'h00;
			psx_q    <= 1'b0;
			slot_q   <= 1'b0;
			sck_o    <= 1'b0;
			cmd_o    <= 1'b0;
			serial_input_zero_o   <= 1'b0;
			dqa_oe_o <= 1'b0;
			dqa_o    <= 6'h00;
			done_q   <= 1'b0;
		end else begin
			active_q <= active_d;
			step_q   <= step_d;
			half_q   <= half_d;
			deep_q   <= deep_d;
			dev_q    <= dev_d;
			psx_q    <= psx_d;
			slot_q   <= slot_d;
			sck_o    <= sck_d;
			cmd_o    <= cmd_d;
			serial_input_zero_o   <= sio_d;
			dqa_oe_o <= oe_d;
			dqa_o    <= dqa_d;
			done_q   <= done_d;
		end
	end

	assign wk.done = done_q;
endmodule
`default_nettype wire

//--- design/dpm_ctrl.sv
// power-state controller for one packet-driven dram device
// assumes a software port on the system clock and a channel-clock-stable
// level from outside that domain; row and column packets leave as strobes
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module dpm_ctrl (
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        rst_b_i,
	// software register port
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic [15:0]      reg_rdata_o,
	// channel clock status
	input  wire logic        chan_clk_stable_i,
	// row packets
	output logic             row_valid_o,
	output logic [2:0]       row_op_o,
	output logic             row_bcast_o,
	output logic [5:0]       row_dev_o,
	// column packets
	output logic             col_valid_o,
	output logic [2:0]       col_op_o,
	output logic [5:0]       col_dev_o,
	// serial pins
	output logic             sck_o,
	output logic             cmd_o,
	output logic             serial_input_zero_o,
	output logic [5:0]       dqa_o,
	output logic             dqa_oe_o
);
	dpm_wake_if wk_if ();

	dpm_pkg::dpm_pwr_t pwr_q, pwr_d;
	dpm_pkg::dpm_seq_t seq_q, seq_d;
	logic [15:0] cfg_q, cfg_d;
	logic [15:0] rdata_d;
	logic        refused_q, refused_d;
	logic        cond_q, cond_d;
	logic        renap_q, renap_d;
	logic [2:0]  kind_q, kind_d;
	logic [7:0]  guard_q, guard_d;
	logic [7:0]  tmr_q, tmr_d;
	logic [3:0]  frame_q, frame_d;
	logic [10:0] nap_q, nap_d;
	logic [6:0]  stab_q, stab_d;
	logic        sync1_q, sync2_q;
	logic        wstart_q, wstart_d, wdeep_q, wdeep_d;
	logic        row_valid_d, row_bcast_d, col_valid_d;
	logic [2:0]  row_op_d, col_op_d;
	logic [5:0]  dev;

	assign dev = cfg_q[dpm_pkg::CFG_DEV_LSB +: 6];

	always_comb begin
		logic       cmd_go;
		logic       bcast;
		logic       awake;
		logic       attention_state_like;
		logic       chan_ok;
		logic       sleep_go;
		logic [3:0] code;
		cmd_go      = reg_wr_i && (reg_addr_i == dpm_pkg::REG_CMD);
		bcast       = reg_wdata_i[dpm_pkg::CMD_BCAST];
		code        = reg_wdata_i[dpm_pkg::CMD_CODE_LSB +: 4];
		awake       = pwr_q != dpm_pkg::deep_sleep_state && pwr_q != dpm_pkg::light_sleep_state;
		attention_state_like   = awake && pwr_q != dpm_pkg::standby_state;
		chan_ok     = stab_q == dpm_pkg::CHAN_STABLE_CYC;
		sleep_go    = 1'b0;
		pwr_d       = pwr_q;
		seq_d       = seq_q;
		cfg_d       = cfg_q;
		cond_d      = cond_q;
		renap_d     = renap_q;
		kind_d      = kind_q;
		wstart_d    = 1'b0;
		wdeep_d     = wdeep_q;
		row_valid_d = 1'b0;
		row_op_d    = row_op_o;
		row_bcast_d = row_bcast_o;
		col_valid_d = 1'b0;
		col_op_d    = col_op_o;
		guard_d     = (guard_q != 8'h00) ? guard_q - 8'h01 : 8'h00;
		tmr_d       = (tmr_q != 8'h00) ? tmr_q - 8'h01 : 8'h00;
		frame_d     = (frame_q != 4'h0) ? frame_q - 4'h1 : 4'h0;
		// light sleep residency, wrapping to zero after 7FF
		nap_d       = (pwr_q == dpm_pkg::light_sleep_state && nap_q != 11'h7FF) ? nap_q + 11'h001 : 11'h000;
		// stability must be seen continuously before a wake
		stab_d      = !sync2_q ? 7'h00 : (chan_ok ? stab_q : stab_q + 7'h01);
		// status read clears the refusal flag; a new refusal below wins
		refused_d   = refused_q && !(reg_rd_i && reg_addr_i == dpm_pkg::REG_STATUS);
		if (reg_wr_i && reg_addr_i == dpm_pkg::REG_CFG) begin
			cfg_d = reg_wdata_i;
		end
		if (cmd_go && seq_q != dpm_pkg::seq_idle) begin
			refused_d = 1'b1;
		end
		unique case (seq_q)
			dpm_pkg::seq_idle: begin
				if (pwr_q == dpm_pkg::light_sleep_state && nap_q >= dpm_pkg::LIGHT_WAKE_AT_CYC
				    && guard_q == 8'h00 && chan_ok) begin
					// limit near: wake now, sleep again later if enabled
					wstart_d = 1'b1;
					wdeep_d  = 1'b0;
					renap_d  = cfg_q[dpm_pkg::CFG_AUTO_RENAP];
					seq_d    = dpm_pkg::seq_wake;
				end else if (renap_q && awake && guard_q == 8'h00) begin
					renap_d  = 1'b0;
					kind_d   = dpm_pkg::ROW_OP_LIGHT;
					seq_d    = dpm_pkg::seq_retire;
				end else if (cmd_go) begin
					unique case (code)
						dpm_pkg::CMD_ACTIVATE, dpm_pkg::CMD_ATTENTION: begin
							if (!awake) begin
								refused_d = 1'b1;
							end else begin
								row_valid_d = 1'b1;
								row_bcast_d = bcast;
								row_op_d    = (code == dpm_pkg::CMD_ACTIVATE) ? dpm_pkg::ROW_OP_ACTIVATE
								                                              : dpm_pkg::ROW_OP_ATTENTION_STATE;
								if (code == dpm_pkg::CMD_ACTIVATE) begin
									cond_d = 1'b0;
								end
								if (!bcast) begin
									frame_d = cfg_q[dpm_pkg::CFG_FRAME_LSB +: 4];
									if (pwr_q == dpm_pkg::standby_state) begin
										pwr_d = dpm_pkg::attention_state;
									end
								end
								// broadcast: power state untouched
							end
						end
						dpm_pkg::CMD_ROW_RELAX: begin
							if (!awake) begin
								refused_d = 1'b1;
							end else begin
								row_valid_d = 1'b1;
								row_bcast_d = bcast;
								row_op_d    = dpm_pkg::ROW_OP_RELAX;
								pwr_d       = dpm_pkg::standby_state;
							end
						end
						dpm_pkg::CMD_COL_RELAX, dpm_pkg::CMD_LOAD, dpm_pkg::CMD_STORE: begin
							// column framing not ready yet after activation
							if (!awake || frame_q != 4'h0) begin
								refused_d = 1'b1;
							end else begin
								col_valid_d = 1'b1;
								if (code == dpm_pkg::CMD_COL_RELAX) begin
									col_op_d = dpm_pkg::COL_OP_RELAX;
									pwr_d    = dpm_pkg::standby_state;
								end else if (code == dpm_pkg::CMD_LOAD) begin
									col_op_d = dpm_pkg::COL_OP_LOAD;
									if (attention_state_like) begin
										pwr_d = dpm_pkg::attention_read_state;
									end
								end else begin
									col_op_d = dpm_pkg::COL_OP_STORE;
									if (attention_state_like) begin
										pwr_d = dpm_pkg::attention_write_state;
									end
								end
							end
						end
						dpm_pkg::CMD_LIGHT, dpm_pkg::CMD_DEEP, dpm_pkg::CMD_COND: begin
							// only from standby or an attention state (plain, read or write), and not inside a guard
							if (!awake || guard_q != 8'h00) begin
								refused_d = 1'b1;
							end else begin
								sleep_go = 1'b1;
								kind_d   = (code == dpm_pkg::CMD_LIGHT) ? dpm_pkg::ROW_OP_LIGHT :
								           (code == dpm_pkg::CMD_DEEP) ? dpm_pkg::ROW_OP_DEEP : dpm_pkg::ROW_OP_COND;
								seq_d    = dpm_pkg::seq_retire;
							end
						end
						dpm_pkg::CMD_WAKE: begin
							// channel clocks must have been stable first
							if (awake || guard_q != 8'h00 || !chan_ok) begin
								refused_d = 1'b1;
							end else begin
								wstart_d = 1'b1;
								wdeep_d  = pwr_q == dpm_pkg::deep_sleep_state;
								renap_d  = 1'b0;
								seq_d    = dpm_pkg::seq_wake;
							end
						end
						default: begin
							refused_d = 1'b1;
						end
					endcase
				end
			end
			dpm_pkg::seq_retire: begin
				col_valid_d = 1'b1;
				col_op_d    = dpm_pkg::COL_OP_RETIRE;
				// without self-refresh in light sleep banks may stay open
				if (kind_q != dpm_pkg::ROW_OP_DEEP && !cfg_q[dpm_pkg::CFG_LIGHT_SR]) begin
					seq_d = dpm_pkg::seq_req;
				end else begin
					seq_d = dpm_pkg::seq_prech;
				end
			end
			dpm_pkg::seq_prech: begin
				col_valid_d = 1'b1;
				col_op_d    = dpm_pkg::COL_OP_PRECH;
				seq_d       = dpm_pkg::seq_req;
			end
			dpm_pkg::seq_req: begin
				row_valid_d = 1'b1;
				row_bcast_d = 1'b0;
				row_op_d    = kind_q;
				tmr_d       = dpm_pkg::ENTRY_QUIET_CYC;
				seq_d       = dpm_pkg::seq_quiet;
				if (kind_q == dpm_pkg::ROW_OP_DEEP) begin
					pwr_d   = dpm_pkg::deep_sleep_state;
					guard_d = dpm_pkg::DEEP_REEXIT_CYC;
				end else if (kind_q == dpm_pkg::ROW_OP_LIGHT || cond_q) begin
					pwr_d   = dpm_pkg::light_sleep_state;
					guard_d = dpm_pkg::LIGHT_REEXIT_CYC;
				end
				if (kind_q == dpm_pkg::ROW_OP_LIGHT) begin
					cond_d = 1'b1;
				end
			end
			dpm_pkg::seq_quiet: begin
				// nothing leaves on row or column until the window closes
				if (tmr_q == 8'h00) begin
					seq_d = dpm_pkg::seq_idle;
				end
			end
			dpm_pkg::seq_wake: begin
				if (wk_if.done) begin
					pwr_d   = dpm_pkg::standby_state;
					guard_d = wdeep_q ? dpm_pkg::DEEP_REENTRY_CYC : dpm_pkg::LIGHT_REENTRY_CYC;
					tmr_d   = dpm_pkg::WAKE_QUIET_CYC;
					seq_d   = dpm_pkg::seq_quiet;
				end
			end
			default: begin
				seq_d = dpm_pkg::seq_idle;
			end
		endcase
		if (sleep_go) begin
			renap_d = 1'b0;
		end
		// read data in the cycle after the strobe only
		rdata_d = 16'h0000;
		if (reg_rd_i) begin
			if (reg_addr_i == dpm_pkg::REG_CFG) begin
				rdata_d = cfg_q;
			end else if (reg_addr_i == dpm_pkg::REG_STATUS) begin
				rdata_d[dpm_pkg::ST_PWR_LSB +: 6] = pwr_q;
				rdata_d[dpm_pkg::ST_BUSY]         = seq_q != dpm_pkg::seq_idle;
				rdata_d[dpm_pkg::ST_REFUSED]      = refused_q;
				rdata_d[dpm_pkg::ST_COND]         = cond_q;
				rdata_d[dpm_pkg::ST_CHAN_OK]      = chan_ok;
				rdata_d[dpm_pkg::ST_RENAP]        = renap_q;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			// mirror starts where the serial reset leaves the device
			pwr_q       <= dpm_pkg::deep_sleep_state;
			seq_q       <= dpm_pkg::seq_idle;
			cfg_q       <= dpm_pkg::CFG_RESET;
			reg_rdata_o <= 16'h0000;
			refused_q   <= 1'b0;
			cond_q      <= 1'b0;
			renap_q     <= 1'b0;
			kind_q      <= dpm_pkg::ROW_OP_LIGHT;
			guard_q     <= 8'h00;
			tmr_q       <= 8'h00;
			frame_q     <= 4'h0;
			nap_q       <= 11'h000;
			stab_q      <= 7'h00;
			sync1_q     <= 1'b0;
			sync2_q     <= 1'b0;
			wstart_q    <= 1'b0;
			wdeep_q     <= 1'b0;
			row_valid_o <= 1'b0;
			row_op_o    <= 3'h0;
			row_bcast_o <= 1'b0;
			row_dev_o   <= 6'h00;
			col_valid_o <= 1'b0;
			col_op_o    <= 3'h0;
			col_dev_o   <= 6'h00;
		end else begin
			pwr_q       <= pwr_d;
			seq_q       <= seq_d;
			cfg_q       <= cfg_d;
			reg_rdata_o <= rdata_d;
			refused_q   <= refused_d;
			cond_q      <= cond_d;
			renap_q     <= renap_d;
			kind_q      <= kind_d;
			guard_q     <= guard_d;
			tmr_q       <= tmr_d;
			frame_q     <= frame_d;
			nap_q       <= nap_d;
			stab_q      <= stab_d;
			sync1_q     <= chan_clk_stable_i;
			sync2_q     <= sync1_q;
			wstart_q    <= wstart_d;
			wdeep_q     <= wdeep_d;
			row_valid_o <= row_valid_d;
			row_op_o    <= row_op_d;
			row_bcast_o <= row_bcast_d;
			row_dev_o   <= dev;
			col_valid_o <= col_valid_d;
			col_op_o    <= col_op_d;
			col_dev_o   <= dev;
		end
	end

	assign wk_if.start = wstart_q;
	assign wk_if.deep  = wdeep_q;
	assign wk_if.dev   = dev;
	assign wk_if.wake_select_bit   = cfg_q[dpm_pkg::CFG_WAKE_SEL];
	assign wk_if.slot  = cfg_q[dpm_pkg::CFG_SLOT_SEL];

	dpm_wake_seq u_wake (
		.clock_i  (clock_i),
		.rst_b_i  (rst_b_i),
		.wk       (wk_if),
		.sck_o    (sck_o),
		.cmd_o    (cmd_o),
		.serial_input_zero_o   (serial_input_zero_o),
		.dqa_o    (dqa_o),
		.dqa_oe_o (dqa_oe_o)
	);
endmodule
`default_nettype wire

//--- verif/dpm_ctrl_props.sv
// pin assertions for the dram power-state controller
// assumes one system clock, reset synchronous and active low
`timescale 1ns/1ns
`default_nettype none
module dpm_ctrl_props (
	// watched pins
	input wire logic       clock_i,
	input wire logic       rst_b_i,
	input wire logic       row_valid_o,
	input wire logic [2:0] row_op_o,
	input wire logic       row_bcast_o,
	input wire logic [5:0] row_dev_o,
	input wire logic       col_valid_o,
	input wire logic [2:0] col_op_o,
	input wire logic       sck_o,
	input wire logic       cmd_o,
	input wire logic       serial_input_zero_o,
	input wire logic [5:0] dqa_o,
	input wire logic       dqa_oe_o
);
	// cycles since last sleep request, saturating so a cold wake passes
	logic [7:0] gap_q;
	logic       deep_q;
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			gap_q  <= 8'hFF;
			deep_q <= 1'b1;
		end else if (row_valid_o && row_op_o >= 3'h4) begin
			gap_q  <= 8'h00;
			deep_q <= row_op_o == 3'h5;
		end else if (gap_q != 8'hFF) begin
			gap_q <= gap_q + 8'h01;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	property p_cmd_fall;
		$rose(cmd_o) |-> $fell(sck_o);
	endproperty
	a_cmd_fall: assert property (p_cmd_fall) else $error("cmd rise off fall");
	property p_cmd_hold;
		$rose(cmd_o) |-> cmd_o [*4] ##1 (!cmd_o && $rose(sck_o));
	endproperty
	a_cmd_hold: assert property (p_cmd_hold) else $error("cmd high span");
	property p_sio;
		$rose(cmd_o) |-> serial_input_zero_o == deep_q && $stable(serial_input_zero_o);
	endproperty
	a_sio: assert property (p_sio) else $error("serial input level");
	property p_dqa;
		dqa_oe_o |-> dqa_o == row_dev_o;
	endproperty
	a_dqa: assert property (p_dqa) else $error("wake number");
	property p_quiet;
		row_valid_o && row_op_o inside {3'h4, 3'h5} |=> !(row_valid_o || col_valid_o) [*5];
	endproperty
	a_quiet: assert property (p_quiet) else $error("entry quiet");
	property p_prep;
		row_valid_o && row_op_o == 3'h5 |-> $past(col_valid_o) && $past(col_op_o) == 3'h2
			&& $past(col_valid_o, 2) && $past(col_op_o, 2) == 3'h1;
	endproperty
	a_prep: assert property (p_prep) else $error("no retire or precharge");
	property p_wake_quiet;
		sck_o |-> !(row_valid_o || col_valid_o);
	endproperty
	a_wake_quiet: assert property (p_wake_quiet) else $error("packet in wake");
	property p_frame;
		row_valid_o && row_op_o == 3'h1 && !row_bcast_o |=> !col_valid_o [*5];
	endproperty
	a_frame: assert property (p_frame) else $error("column too early");
	property p_guard;
		$rose(sck_o) |-> gap_q >= (deep_q ? 8'h62 : 8'h17);
	endproperty
	a_guard: assert property (p_guard) else $error("wake inside guard");
	c_wake: cover property ($rose(cmd_o));
	c_deep: cover property (row_valid_o && row_op_o == 3'h5);
	c_sel: cover property ($rose(dqa_oe_o));
endmodule
bind dpm_ctrl dpm_ctrl_props dpm_ctrl_props_i (.clock_i, .rst_b_i, .row_valid_o, .row_op_o, .row_bcast_o,
	.row_dev_o, .col_valid_o, .col_op_o, .sck_o, .cmd_o, .serial_input_zero_o, .dqa_o, .dqa_oe_o);
`default_nettype wire

//--- verif/dpm_dev_model.sv
// device model: power state from the controller's pins
// assumes pins on the system clock; serial edges found by sampling
`timescale 1ns/1ns
`default_nettype none
module dpm_dev_model #(
	parameter logic [5:0] DEV = 6'h05
) (
	// inputs
	input wire logic              clock_i,
	input wire logic              rst_b_i,
	input wire logic              psx_i,
	input wire logic              row_valid_i,
	input wire logic [2:0]        row_op_i,
	input wire logic              row_bcast_i,
	input wire logic [5:0]        row_dev_i,
	input wire logic              col_valid_i,
	input wire logic [2:0]        col_op_i,
	input wire logic              sck_i,
	input wire logic              cmd_i,
	input wire logic              serial_input_zero_i,
	input wire logic [5:0]        dqa_i,
	input wire logic              dqa_oe_i,
	// state
	output var dpm_pkg::dpm_pwr_t pwr_o
);
	logic       flag_q, sck_q, cmd_q, sio_q, oe_q, fcmd_q, fsio_q, arm_q;
	logic [5:0] dqa_q;
	logic       sl, dp, me, rise, hit;
	assign dp   = pwr_o == dpm_pkg::deep_sleep_state;
	assign sl   = dp || pwr_o == dpm_pkg::light_sleep_state;
	assign me   = row_valid_i && !sl && (row_bcast_i || row_dev_i == DEV);
	assign rise = !sck_q && sck_i;
	assign hit  = rise && oe_q && dqa_q == DEV;
	always_ff @(posedge clock_i) begin
		sck_q <= sck_i;
		cmd_q <= cmd_i;
		sio_q <= serial_input_zero_i;
		oe_q  <= dqa_oe_i;
		dqa_q <= dqa_i;
		if (!rst_b_i) begin
			pwr_o  <= dpm_pkg::deep_sleep_state;
			flag_q <= 1'b0;
			arm_q  <= 1'b0;
			fcmd_q <= 1'b1;
		end else begin
			if (me) begin
				case (row_op_i)
					dpm_pkg::ROW_OP_ACTIVATE, dpm_pkg::ROW_OP_ATTENTION_STATE: begin
						if (!row_bcast_i && pwr_o == dpm_pkg::standby_state)
							pwr_o <= dpm_pkg::attention_state;
						if (!row_bcast_i && row_op_i == dpm_pkg::ROW_OP_ACTIVATE)
							flag_q <= 1'b0;
					end
					dpm_pkg::ROW_OP_RELAX: pwr_o <= dpm_pkg::standby_state;
					dpm_pkg::ROW_OP_LIGHT: begin
						pwr_o  <= dpm_pkg::light_sleep_state;
						flag_q <= 1'b1;
					end
					dpm_pkg::ROW_OP_DEEP: pwr_o <= dpm_pkg::deep_sleep_state;
					dpm_pkg::ROW_OP_COND: if (flag_q) pwr_o <= dpm_pkg::light_sleep_state;
					default: ;
				endcase
			end
			if (col_valid_i && !sl && pwr_o != dpm_pkg::standby_state) begin
				case (col_op_i)
					dpm_pkg::COL_OP_RELAX: pwr_o <= dpm_pkg::standby_state;
					dpm_pkg::COL_OP_LOAD: pwr_o <= dpm_pkg::attention_read_state;
					dpm_pkg::COL_OP_STORE: pwr_o <= dpm_pkg::attention_write_state;
					default: ;
				endcase
			end
			// pins sampled just before each serial fall
			if (sck_q && !sck_i) begin
				fcmd_q <= cmd_q;
				fsio_q <= sio_q;
			end
			// late slot: armed at the first rise, judged at the next one
			if (rise && sl && !fcmd_q && cmd_q && fsio_q == dp) begin
				arm_q <= !(psx_i || hit);
				if (psx_i || hit) pwr_o <= dpm_pkg::standby_state;
			end else if (rise && arm_q) begin
				arm_q <= 1'b0;
				if (hit && sl && !psx_i) pwr_o <= dpm_pkg::standby_state;
			end
		end
	end
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench: controller driving the device model
// assumes the controller package and both modules compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic              clock_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic              chan_clk_stable_i = 1'b1, wake_select_bit = 1'b0;
	logic [3:0]        reg_addr_i = 4'h0;
	logic [15:0]       reg_wdata_i = 16'h0000, v;
	wire logic [15:0]  reg_rdata_o;
	wire logic         row_valid_o, row_bcast_o, col_valid_o, sck_o, cmd_o, serial_input_zero_o, dqa_oe_o;
	wire logic [2:0]   row_op_o, col_op_o;
	wire logic [5:0]   row_dev_o, col_dev_o, dqa_o;
	dpm_pkg::dpm_pwr_t pwr;
	int                n_mismatch = 0, comparisons = 0;
	always #4 clock_i = ~clock_i;
	dpm_ctrl dpm_ctrl_i (.clock_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.chan_clk_stable_i, .row_valid_o, .row_op_o, .row_bcast_o, .row_dev_o, .col_valid_o, .col_op_o,
		.col_dev_o, .sck_o, .cmd_o, .serial_input_zero_o, .dqa_o, .dqa_oe_o);
	dpm_dev_model dpm_dev_model_i (.clock_i, .rst_b_i, .psx_i(wake_select_bit), .row_valid_i(row_valid_o),
		.row_op_i(row_op_o), .row_bcast_i(row_bcast_o), .row_dev_i(row_dev_o), .col_valid_i(col_valid_o),
		.col_op_i(col_op_o), .sck_i(sck_o), .cmd_i(cmd_o), .serial_input_zero_i(serial_input_zero_o), .dqa_i(dqa_o),
		.dqa_oe_i(dqa_oe_o), .pwr_o(pwr));
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask
	// device state first, then the mirror, which may trail a wake
	task automatic st(input logic [5:0] e);
		int i;
		repeat (4) @(posedge clock_i);
		for (i = 0; i < 300 && pwr !== e; i++) @(posedge clock_i);
		chk({10'h000, pwr}, {10'h000, e});
		v = 16'h0000;
		for (i = 0; i < 20 && v[5:0] !== e; i++) rd(dpm_pkg::REG_STATUS);
		chk({10'h000, v[5:0]}, {10'h000, e});
		repeat (8) @(posedge clock_i);
	endtask
	task automatic s_reset();
		rd(dpm_pkg::REG_CFG);
		chk(v, 16'h00BA);
		rd(4'hF);
		chk(v, 16'h0000);
		st(6'h01);
		wr(dpm_pkg::REG_CFG, 16'h05BA);
		repeat (60) @(posedge clock_i);
	endtask
	task automatic s_attention_state();
		wr(dpm_pkg::REG_CMD, 16'h000A);
		st(6'h02);
		wr(dpm_pkg::REG_CMD, 16'h0001);
		wr(dpm_pkg::REG_CMD, 16'h0005);
		rd(dpm_pkg::REG_STATUS);
		chk({15'h0000, v[7]}, 16'h0001);
		st(6'h04);
		wr(dpm_pkg::REG_CMD, 16'h0005);
		st(6'h08);
		wr(dpm_pkg::REG_CMD, 16'h0006);
		st(6'h10);
		wr(dpm_pkg::REG_CMD, 16'h0004);
		st(6'h02);
	endtask
	task automatic s_bcast();
		wr(dpm_pkg::REG_CMD, 16'h0012);
		st(6'h02);
		wr(dpm_pkg::REG_CMD, 16'h0002);
		st(6'h04);
		wr(dpm_pkg::REG_CMD, 16'h0013);
		st(6'h02);
	endtask
	task automatic s_light();
		wr(dpm_pkg::REG_CMD, 16'h0007);
		st(6'h20);
		repeat (30) @(posedge clock_i);
		wr(dpm_pkg::REG_CMD, 16'h000A);
		st(6'h02);
		repeat (30) @(posedge clock_i);
		wr(dpm_pkg::REG_CMD, 16'h0009);
		st(6'h20);
		repeat (1000) @(posedge clock_i);
		st(6'h02);
		st(6'h20);
		repeat (30) @(posedge clock_i);
		wr(dpm_pkg::REG_CMD, 16'h000A);
		st(6'h02);
		repeat (30) @(posedge clock_i);
		wr(dpm_pkg::REG_CMD, 16'h0001);
		st(6'h04);
		wr(dpm_pkg::REG_CMD, 16'h0003);
		st(6'h02);
		wr(dpm_pkg::REG_CMD, 16'h0009);
		repeat (10) @(posedge clock_i);
		st(6'h02);
	endtask
	task automatic s_deep();
		wake_select_bit <= 1'b1;
		wr(dpm_pkg::REG_CFG, 16'h05BB);
		wr(dpm_pkg::REG_CMD, 16'h0008);
		st(6'h01);
		repeat (110) @(posedge clock_i);
		wr(dpm_pkg::REG_CMD, 16'h000A);
		st(6'h02);
	endtask
	task automatic complete_run();
		if (n_mismatch == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clock_i);
		rst_b_i <= 1'b1;
		s_reset();
		s_attention_state();
		s_bcast();
		s_light();
		s_deep();
		complete_run();
	end
	initial begin
		#200000;
		n_mismatch++;
		complete_run();
	end
endmodule
`default_nettype wire
